/* File: pkg/sapc_pkg.sv */
/*
 * Constants for the secondary alert pin configuration block: command codes,
 * configuration word layout, reset value and pin mode encodings.
 * Assumes a PMBus front end that hands over decoded command transactions.
 */
package sapc_pkg;

   // Command codes seen on the command port
   localparam logic [7:0] CMD_ALERT2_CFG = 8'hd6;
   localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;

   // Configuration word
   localparam int CFG_WIDTH = 16;
   localparam logic [15:0] CFG_RESET = 16'h8000;

   // Field positions inside the configuration word
   localparam int POS_POLARITY = 0;
   localparam int POS_MODE_LO = 1;
   localparam int POS_MODE_HI = 2;
   localparam int POS_OVERPOWER_EN = 3;
   localparam int POS_CURLIM_EN = 4;
   localparam int POS_VOUT_UV_EN = 5;
   localparam int POS_VOUT_OV_EN = 6;
   localparam int POS_VIN_UV_EN = 7;
   localparam int POS_VIN_OV_EN = 8;
   localparam int POS_CUR2_EN = 9;
   localparam int POS_OC_WARN_EN = 10;
   localparam int POS_CML_EN = 11;
   localparam int POS_VIN_UV_FAULT_EN = 12;
   localparam int POS_VIN_OV_FAULT_EN = 13;
   localparam int POS_OC_FAULT_EN = 14;
   localparam int POS_FET_HEALTH_EN = 15;

   // Source counts: warnings occupy bits 10..3, faults bits 15..11
   localparam int N_WARN = 8;
   localparam int N_FAULT = 5;
   localparam int N_SRC = N_WARN + N_FAULT;
   localparam int POS_SRC_LO = 3;

   // Pin mode encodings
   localparam logic [1:0] MODE_ALERT = 2'h0;
   localparam logic [1:0] MODE_GPO = 2'h1;
   localparam logic [1:0] MODE_RESERVED = 2'h2;
   localparam logic [1:0] MODE_COMPARE = 2'h3;

   // Command answer states, one-hot
   typedef enum logic [1:0] {
      ST_IDLE = 2'h1,
      ST_ANSWER = 2'h2
   } sapc_state_t;

endpackage : sapc_pkg

/* File: pkg/sapc_src_if.sv */
/*
 * Carrier between the configuration block and its alert latch bank.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface sapc_src_if #(
   parameter int N = 13
);
   logic [N-1:0] flag;
   logic [N-1:0] enable;
   logic clear;
   logic [N-1:0] pending;
   logic any;

   modport ctrl (output flag, output enable, output clear, input pending, input any);
   modport latch (input flag, input enable, input clear, output pending, output any);
endinterface : sapc_src_if

/* File: rtl/sapc_latch.sv */
/*
 * Bank of sticky alert latches, one per status source.
 * A source that rises while enabled sets its latch; clear empties all latches except those set in the same cycle.
 * Assumes flags are synchronous to clk.
 */
`timescale 1ns/10ps
module sapc_latch #(
   parameter int N = 13
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Sources and results
   sapc_src_if.latch src
);

   logic [N-1:0] prev_q;
   logic [N-1:0] prev_d;
   logic [N-1:0] pend_q;
   logic [N-1:0] pend_d;
   logic any_q;
   logic any_d;

   always_comb begin
      prev_d = src.flag;
      // Set takes priority over a clear arriving in the same cycle
      pend_d = (src.flag & ~prev_q & src.enable) | (pend_q & {N{~src.clear}});
      any_d = |pend_d;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_q <= '0;
         pend_q <= '0;
         any_q <= 1'b0;
      end else begin
         prev_q <= prev_d;
         pend_q <= pend_d;
         any_q <= any_d;
      end
   end

   assign src.pending = pend_q;
   assign src.any = any_q;

endmodule : sapc_latch

/* File: rtl/sapc_top.sv */
/*
 * Secondary alert pin configuration: holds the 16-bit configuration word
 * reached by PMBus command 0xd6, latches enabled status events into a bus
 * alert, and drives the secondary output pin in alert, software or
 * comparator mode with selectable polarity.
 * Assumes a PMBus front end delivering one decoded command per strobe and
 * status flags synchronous to clk.
 */
//
// Contract
// - Overcurrent warning rise raises alert when enabled
// - Bit 9 gates secondary current warning alert
// - Bit 8 gates input overvoltage warning alert
// - Bit 7 gates input undervoltage warning alert
// - Bit 6 gates output overvoltage warning alert
// - Bit 5 gates output undervoltage warning alert
// - Bit 4 gates current limit alert
// - Bit 3 gates input overpower warning alert
// - Warning enables reset to zero
// - Mode 00 makes pin the alert output
// - Mode 01 pin level follows polarity bit
// - Mode 11 pin shows live warnings, unlatched
// - Comparator ORs all selected warnings
// - Comparator ignores fault enables
// - Polarity 0 drives pin active low
// - Config word resets to 0x8000, read/write
`timescale 1ns/10ps
module sapc_top (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Decoded PMBus command port
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic cmd_write,
   input wire logic [15:0] cmd_wdata,
   output logic rsp_valid,
   output logic rsp_ack,
   output logic [15:0] rsp_rdata,
   // Warning comparison results
   input wire logic overcurrent_warning_flag,
   input wire logic secondary_current_warning_flag,
   input wire logic input_overvoltage_warning_flag,
   input wire logic input_undervoltage_warning_flag,
   input wire logic output_overvoltage_warning_flag,
   input wire logic output_undervoltage_warning_flag,
   input wire logic current_limit_active_flag,
   input wire logic input_overpower_warning_flag,
   // Fault status flags
   input wire logic fet_health_bad_flag,
   input wire logic overcurrent_fault_flag,
   input wire logic input_overvoltage_fault_flag,
   input wire logic input_undervoltage_fault_flag,
   input wire logic comm_error_flag,
   // Pin and alert state
   output logic secondary_output_pin,
   output logic alert_pending
);

   // Configuration register
   logic [15:0] cfg_q;
   logic [15:0] cfg_d;

   // Command answer machine
   sapc_pkg::sapc_state_t state_q;
   sapc_pkg::sapc_state_t state_d;
   logic rsp_valid_q;
   logic rsp_valid_d;
   logic rsp_ack_q;
   logic rsp_ack_d;
   logic [15:0] rsp_rdata_q;
   logic [15:0] rsp_rdata_d;
   logic clear_q;
   logic clear_d;

   // Pin
   logic pin_q;
   logic pin_d;
   logic pin_active;
   logic [1:0] mode;
   logic polarity;

   // Source vectors
   logic [sapc_pkg::N_WARN-1:0] warn_vec;
   logic [sapc_pkg::N_FAULT-1:0] fault_vec;
   logic [sapc_pkg::N_WARN-1:0] warn_en;
   logic compare_hit;

   sapc_src_if #(.N(sapc_pkg::N_SRC)) src ();

   // Warnings in bit order 3..10 of the configuration word
   always_comb begin
      warn_vec = {
         overcurrent_warning_flag,
         secondary_current_warning_flag,
         input_overvoltage_warning_flag,
         input_undervoltage_warning_flag,
         output_overvoltage_warning_flag,
         output_undervoltage_warning_flag,
         current_limit_active_flag,
         input_overpower_warning_flag
      };
      fault_vec = {
         fet_health_bad_flag,
         overcurrent_fault_flag,
         input_overvoltage_fault_flag,
         input_undervoltage_fault_flag,
         comm_error_flag
      };
   end

   assign src.flag = {fault_vec, warn_vec};
   assign src.enable = cfg_q[sapc_pkg::POS_FET_HEALTH_EN:sapc_pkg::POS_SRC_LO];
   assign src.clear = clear_q;

   sapc_latch #(
      .N(sapc_pkg::N_SRC)
   ) u_latch (
      .clk(clk),
      .rst_n(rst_n),
      .src(src)
   );

   // Command decode and register write
   always_comb begin
      cfg_d = cfg_q;
      state_d = state_q;
      rsp_valid_d = 1'b0;
      rsp_ack_d = rsp_ack_q;
      rsp_rdata_d = rsp_rdata_q;
      clear_d = 1'b0;
      case (state_q)
         sapc_pkg::ST_IDLE: begin
            if (cmd_valid) begin
               state_d = sapc_pkg::ST_ANSWER;
               rsp_valid_d = 1'b1;
               rsp_ack_d = 1'b0;
               rsp_rdata_d = 16'h0000;
               if (cmd_code == sapc_pkg::CMD_ALERT2_CFG) begin
                  rsp_ack_d = 1'b1;
                  if (cmd_write) begin
                     cfg_d = cmd_wdata;
                  end else begin
                     rsp_rdata_d = cfg_q;
                  end
               end else if (cmd_code == sapc_pkg::CMD_CLEAR_FAULTS && cmd_write) begin
                  rsp_ack_d = 1'b1;
                  clear_d = 1'b1;
               end
            end
         end
         sapc_pkg::ST_ANSWER: begin
            state_d = sapc_pkg::ST_IDLE;
         end
         default: begin
            state_d = sapc_pkg::ST_IDLE;
         end
      endcase
   end

   // Pin level selection
   always_comb begin
      mode = cfg_q[sapc_pkg::POS_MODE_HI:sapc_pkg::POS_MODE_LO];
      polarity = cfg_q[sapc_pkg::POS_POLARITY];
      warn_en = cfg_q[sapc_pkg::POS_OC_WARN_EN:sapc_pkg::POS_SRC_LO];
      compare_hit = |(warn_vec & warn_en);
      pin_active = src.any;
      case (mode)
         sapc_pkg::MODE_GPO: begin
            pin_active = polarity;
         end
         sapc_pkg::MODE_COMPARE: begin
            pin_active = compare_hit;
         end
         default: begin
            pin_active = src.any;
         end
      endcase
      // polarity select
      // Software mode takes the polarity bit as the level itself
      pin_d = (mode == sapc_pkg::MODE_GPO) ? polarity : (polarity ? pin_active : ~pin_active);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q <= sapc_pkg::CFG_RESET;
         state_q <= sapc_pkg::ST_IDLE;
         rsp_valid_q <= 1'b0;
         rsp_ack_q <= 1'b0;
         rsp_rdata_q <= 16'h0000;
         clear_q <= 1'b0;
         pin_q <= 1'b1;
      end else begin
         cfg_q <= cfg_d;
         state_q <= state_d;
         rsp_valid_q <= rsp_valid_d;
         rsp_ack_q <= rsp_ack_d;
         rsp_rdata_q <= rsp_rdata_d;
         clear_q <= clear_d;
         pin_q <= pin_d;
      end
   end

   assign rsp_valid = rsp_valid_q;
   assign rsp_ack = rsp_ack_q;
   assign rsp_rdata = rsp_rdata_q;
   assign secondary_output_pin = pin_q;
   assign alert_pending = src.any;

endmodule : sapc_top

/* File: bench/sapc_top_monitor.sv */
/* Port checker for sapc_top: command answers, alert latching, pin modes.
   Assumes it is bound into sapc_top with ports matched by name. */
`timescale 1ns/10ps
module sapc_top_monitor (
   // Clock, reset and command port
   input wire logic clk, rst_n, cmd_valid, cmd_write, rsp_valid, rsp_ack,
   input wire logic [7:0] cmd_code,
   input wire logic [15:0] cmd_wdata, rsp_rdata,
   // Status sources
   input wire logic fet_health_bad_flag, overcurrent_fault_flag, input_overvoltage_fault_flag,
   input wire logic input_undervoltage_fault_flag, comm_error_flag, overcurrent_warning_flag,
   input wire logic secondary_current_warning_flag, input_overvoltage_warning_flag,
   input wire logic input_undervoltage_warning_flag, output_overvoltage_warning_flag,
   input wire logic output_undervoltage_warning_flag, current_limit_active_flag,
   input wire logic input_overpower_warning_flag,
   // Pin and alert
   input wire logic secondary_output_pin, alert_pending
);
   logic [15:0] cfg_q, cfg_d;
   logic [12:0] src, src_q, rise;
   logic take, clr, cmp;
   assign take = cmd_valid && !rsp_valid;
   assign clr = take && cmd_write && cmd_code == 8'h03;
   assign src = {fet_health_bad_flag, overcurrent_fault_flag, input_overvoltage_fault_flag,
      input_undervoltage_fault_flag, comm_error_flag, overcurrent_warning_flag,
      secondary_current_warning_flag, input_overvoltage_warning_flag,
      input_undervoltage_warning_flag, output_overvoltage_warning_flag,
      output_undervoltage_warning_flag, current_limit_active_flag,
      input_overpower_warning_flag};
   assign rise = src & ~src_q & cfg_q[15:3];
   assign cmp = |(src[7:0] & cfg_q[10:3]);
   always_comb begin
      cfg_d = (take && cmd_write && cmd_code == 8'hd6) ? cmd_wdata : cfg_q;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q <= 16'h8000;
         src_q <= 13'h0;
      end else begin
         cfg_q <= cfg_d;
         src_q <= src;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_clear;
      clr ##1 !(|rise);
   endsequence
   a_answer_next: assert property (take |=> rsp_valid)
      else $error("no answer one cycle after a command");
   a_read_back: assert property (take && !cmd_write && cmd_code == 8'hd6 |=> rsp_ack && rsp_rdata == cfg_q)
      else $error("configuration read differs from written word");
   a_unknown_nack: assert property (take && cmd_code != 8'hd6 && cmd_code != 8'h03 |=> !rsp_ack && rsp_rdata == 16'h0)
      else $error("unknown command not refused");
   a_alert_latch: assert property (|rise |=> alert_pending)
      else $error("enabled rise did not raise alert");
   a_alert_hold: assert property (alert_pending && !$past(clr) |=> alert_pending)
      else $error("alert dropped without clear");
   a_clear_empties: assert property (s_clear |=> !alert_pending)
      else $error("alert not emptied by clear");
   a_alert_pin: assert property (cfg_q[2:1] == 2'h0 |=> secondary_output_pin == ($past(cfg_q[0]) ~^ $past(alert_pending)))
      else $error("alert mode pin level wrong");
   a_gpo_level: assert property (cfg_q[2:1] == 2'h1 |=> secondary_output_pin == $past(cfg_q[0]))
      else $error("software mode pin level wrong");
   a_compare_live: assert property (cfg_q[2:1] == 2'h3 |=> secondary_output_pin == ($past(cfg_q[0]) ~^ $past(cmp)))
      else $error("comparator pin level wrong");
endmodule : sapc_top_monitor

/* File: bench/sapc_host_model.sv */
/* Host side of the decoded command port, one word transfer at a time.
   Assumes the answer strobe follows a taken command. */
`timescale 1ns/10ps
module sapc_host_model (
   // Clock
   input wire logic clk,
   // Command and answer
   output logic cmd_valid,
   output logic [7:0] cmd_code,
   output logic cmd_write,
   output logic [15:0] cmd_wdata,
   input wire logic rsp_valid,
   input wire logic rsp_ack,
   input wire logic [15:0] rsp_rdata
);
   initial begin
      cmd_valid = 1'b0;
      cmd_code = 8'h5a;
      cmd_write = 1'b0;
      cmd_wdata = 16'ha5c3;
   end
   // Held through the edge after the answer; a missing answer returns unknowns
   task automatic xfer(input logic [7:0] c, input logic w, input logic [15:0] d,
         output logic [15:0] rd, output logic ak);
      int n;
      n = 0;
      @(posedge clk);
      #1;
      cmd_valid = 1'b1;
      cmd_code = c;
      cmd_write = w;
      cmd_wdata = d;
      @(posedge clk);
      #1;
      while (rsp_valid !== 1'b1 && n < 4) begin
         @(posedge clk);
         #1;
         n++;
      end
      rd = (rsp_valid === 1'b1) ? rsp_rdata : 'x;
      ak = (rsp_valid === 1'b1) ? rsp_ack : 1'bx;
      @(posedge clk);
      #1;
      cmd_valid = 1'b0;
      cmd_code = ~c;
      cmd_write = ~w;
      cmd_wdata = ~d;
   endtask : xfer
endmodule : sapc_host_model

/* File: bench/test_secondary_alert_output_config.sv */
/* Self-checking bench for sapc_top with a host model and random sources.
   Assumes sapc_top_monitor and sapc_host_model are compiled beforehand. */
`timescale 1ns/10ps
module test_secondary_alert_output_config;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [12:0] src = 13'h0;
   logic cmd_valid, cmd_write, rsp_valid, rsp_ack, secondary_output_pin, alert_pending, ak, p;
   logic [7:0] cmd_code;
   logic [15:0] cmd_wdata, rsp_rdata, rd, cfg, w;
   int n_fail = 0;
   int comparisons = 0;
   initial begin
      forever #5 clk = ~clk;
   end
   sapc_host_model host_u (.*);
   sapc_top dut_u (.*, .fet_health_bad_flag(src[12]), .overcurrent_fault_flag(src[11]),
      .input_overvoltage_fault_flag(src[10]), .input_undervoltage_fault_flag(src[9]),
      .comm_error_flag(src[8]), .overcurrent_warning_flag(src[7]),
      .secondary_current_warning_flag(src[6]), .input_overvoltage_warning_flag(src[5]),
      .input_undervoltage_warning_flag(src[4]), .output_overvoltage_warning_flag(src[3]),
      .output_undervoltage_warning_flag(src[2]), .current_limit_active_flag(src[1]),
      .input_overpower_warning_flag(src[0]));
   function automatic logic exp_pin(input logic [15:0] c, input logic [12:0] s, input logic l);
      logic a;
      a = (c[2:1] == 2'h3) ? |(s[7:0] & c[10:3]) : l;
      return (c[2:1] == 2'h1) ? c[0] : (c[0] ? a : !a);
   endfunction : exp_pin
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk16
   task automatic chk1(input logic got, input logic exp);
      chk16({15'h0, got}, {15'h0, exp});
   endtask : chk1
   task automatic wcfg(input logic [15:0] c);
      host_u.xfer(8'hd6, 1'b1, c, rd, ak);
      cfg = c;
      chk1(ak, 1'b1);
   endtask : wcfg
   task automatic tally_and_finish();
      if (n_fail == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic wait2();
      repeat (2) @(posedge clk);
      #1;
   endtask : wait2
   initial begin
      #100000;
      n_fail++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(32'h7cfeae1e));
      repeat (3) @(posedge clk);
      #1 rst_n = 1'b1;
      src = 13'h0ff;
      wait2();
      chk1(alert_pending, 1'b0);
      chk1(secondary_output_pin, 1'b1);
      src = 13'h0;
      host_u.xfer(8'hd6, 1'b0, 16'h0, rd, ak);
      chk16(rd, 16'h8000);
      w = 16'($urandom);
      w[2] = 1'b0;
      wcfg(w);
      host_u.xfer(8'hd6, 1'b0, 16'h0, rd, ak);
      chk16(rd, w);
      host_u.xfer(8'hd7, 1'b0, 16'h0, rd, ak);
      chk16({rd[15:1], ak}, 16'h0);
      for (int i = 0; i < 13; i++) begin
         p = 1'($urandom);
         wcfg((16'h8 << i) | 16'(p));
         host_u.xfer(8'h03, 1'b1, 16'h0, rd, ak);
         chk1(alert_pending, 1'b0);
         src[i] = 1'b1;
         wait2();
         chk1(alert_pending, 1'b1);
         chk1(secondary_output_pin, exp_pin(cfg, src, 1'b1));
         src[i] = 1'b0;
         wcfg(16'(p));
         chk1(alert_pending, 1'b1);
         host_u.xfer(8'h03, 1'b1, 16'h0, rd, ak);
         src[i] = 1'b1;
         wait2();
         chk1(alert_pending, 1'b0);
         src[i] = 1'b0;
      end
      for (int k = 0; k < 2; k++) begin
         wcfg({13'h0, 2'h1, k[0]});
         chk1(secondary_output_pin, k[0]);
      end
      for (int k = 0; k < 64; k++) begin
         if (k % 16 == 0) begin
            w = 16'($urandom);
            w[2:1] = 2'h3;
            wcfg(w);
         end
         src = 13'($urandom);
         wait2();
         chk1(secondary_output_pin, exp_pin(cfg, src, 1'b0));
      end
      rst_n = 1'b0;
      @(posedge clk);
      #1 rst_n = 1'b1;
      chk1(alert_pending, 1'b0);
      chk1(secondary_output_pin, 1'b1);
      host_u.xfer(8'hd6, 1'b0, 16'h0, rd, ak);
      chk16(rd, 16'h8000);
      tally_and_finish();
   end
endmodule : test_secondary_alert_output_config
bind sapc_top sapc_top_monitor mon_u (.*);
